// *** verilog/flash_ctrl_pkg.sv ***
// shared constants, register map and types of the flash command controller
package flash_ctrl_pkg;

  // apb byte offsets
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_MODE      = 8'h04;
  localparam logic [7:0] OFF_COMMAND   = 8'h08;
  localparam logic [7:0] OFF_DATA      = 8'h0c;
  localparam logic [7:0] OFF_ADDRESS   = 8'h10;
  localparam logic [7:0] OFF_SIGNATURE = 8'h18;
  localparam logic [7:0] OFF_DEFERRED  = 8'h1c;
  localparam logic [7:0] OFF_IMMEDIATE = 8'h20;

  // command codes
  localparam logic [3:0] CMD_NULL       = 4'h0;
  localparam logic [3:0] CMD_READ       = 4'h1;
  localparam logic [3:0] CMD_WRITE      = 4'h2;
  localparam logic [3:0] CMD_ERASE_WR   = 4'h3;
  localparam logic [3:0] CMD_VERIFY     = 4'h4;
  localparam logic [3:0] CMD_ERASE_PAGE = 4'h5;
  localparam logic [3:0] CMD_MASS_ERASE = 4'h6;
  localparam logic [3:0] CMD_EXECUTED   = 4'h7;
  localparam logic [3:0] CMD_SIGNATURE  = 4'hb;
  localparam logic [3:0] CMD_PROTECT    = 4'hc;
  localparam logic [3:0] CMD_PING       = 4'hf;

  // status and mode fields
  localparam int STA_DONE     = 0;
  localparam int STA_FAIL     = 1;
  localparam int STA_BUSY     = 2;
  localparam int STA_IRQ      = 3;
  localparam int MOD_ERASE_EN = 3;
  localparam int MOD_IRQ_EN   = 4;
  localparam int PROT_READ    = 31;

  // reset values
  localparam logic [7:0]  MODE_RESET      = 8'h80;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  localparam logic [15:0] ADDRESS_RESET   = 16'h0000;
  localparam logic [23:0] SIGNATURE_RESET = 24'hffffff;
  localparam logic [31:0] DEFERRED_RESET  = 32'h00000000;
  localparam logic [31:0] IMMEDIATE_RESET = 32'hffffffff;
  localparam logic [31:0] PROT_OPEN       = 32'hffffffff;

  // mass erase keys
  localparam logic [15:0] MASS_KEY_DATA = 16'h3cff;
  localparam logic [15:0] MASS_KEY_ADDR = 16'hffc3;

  // page geometry: 512 byte pages, 128 per block
  localparam int         PAGE_LSB          = 9;
  localparam logic [6:0] KERNEL_FIRST_PAGE = 7'd124;
  localparam logic [6:0] WIDE_GROUP_FIRST  = 7'd120;
  localparam logic [4:0] WIDE_GROUP_BIT    = 5'd30;

  // timing at 25 MHz
  localparam longint CLK_HZ             = 25_000_000;
  localparam longint WRITE_TIME_NS      = 50_000;
  localparam longint ERASE_WRITE_TIME_US = 20_000;
  localparam longint MASS_ERASE_TIME_MS = 2_480;
  localparam int     TIMER_W            = 26;
  localparam logic [TIMER_W-1:0] WRITE_CYCLES =
    TIMER_W'((WRITE_TIME_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam logic [TIMER_W-1:0] ERASE_WRITE_CYCLES =
    TIMER_W'((ERASE_WRITE_TIME_US * CLK_HZ + 999_999) / 1_000_000);
  localparam logic [TIMER_W-1:0] MASS_ERASE_CYCLES =
    TIMER_W'((MASS_ERASE_TIME_MS * CLK_HZ + 999) / 1_000);
  localparam logic [15:0] SIGNATURE_CYCLES = 16'd32778;
  localparam logic [15:0] SIGN_WORDS       = 16'h8000;
  localparam logic [23:0] SIGN_POLY        = 24'h864cfb;

  // arbitrary value, no meaning beyond this design
  localparam logic [15:0] PROTECT_KEY = 16'h5a5a;

  typedef enum logic [2:0] {
    ARR_NONE, ARR_READ, ARR_WRITE, ARR_ERASE_PAGE, ARR_ERASE_USER, ARR_STORE_PROT
  } array_op_t;

  typedef struct packed {
    array_op_t   op;
    logic [15:0] addr;
    logic [31:0] wdata;
  } array_req_t;

endpackage : flash_ctrl_pkg

// *** verilog/page_guard.sv ***
// read and write permission of one address under a protection word
`timescale 1ns/100ps
module page_guard
  import flash_ctrl_pkg::*;
(
  input  wire logic [31:0] prot_word,
  input  wire logic [15:0] addr,
  input  wire logic        is_block1,
  output logic             read_ok,
  output logic             write_ok
);
  wire logic [6:0] page      = addr[15:PAGE_LSB];
  wire logic       wide_grp  = is_block1 && (page >= WIDE_GROUP_FIRST);
  // kernel pages of block 0 never take a user write
  wire logic       kernel    = !is_block1 && (page >= KERNEL_FIRST_PAGE);
  wire logic [4:0] group_bit = wide_grp ? WIDE_GROUP_BIT : page[6:2];

  assign read_ok  = prot_word[PROT_READ];
  assign write_ok = !kernel && prot_word[group_bit];
endmodule : page_guard

// *** verilog/op_timer.sv ***
// down counter timing one array operation
`timescale 1ns/100ps
module op_timer
  import flash_ctrl_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] load,
  output logic                    expired
);
  logic [TIMER_W-1:0] count;

  // pulse in the last counted cycle
  assign expired = clk_en && (count == TIMER_W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clk_en) begin
      if (start) begin
        count <= load;
      end else if (count != '0) begin
        count <= count - TIMER_W'(1);
      end
    end
  end
endmodule : op_timer

// *** verilog/flash_command_protect_ctrl.sv ***
// flash command sequencer with page protection and fetch port, apb slave
// Function
// - command 1 reads addressed word into data
// - command 2 programs data word, 50 us
// - command 3 erases page then writes, 20 ms
// - command 4 verifies word, mismatch sets fail
// - command 5 erases only the addressed page
// - command 6 erases user space, keeps kernel
// - mass erase refused without key sequence
// - command 11 builds 24-bit signature, 32778 cycles
// - command 12 stores protection once, key unlocks
// - command 15 only completes and raises interrupt
// - codes 0 to 6 leave command reading 7
// - block 0 bit 31 clear forbids reads
// - block 0 low bits guard page groups
// - block 1 bit 31 clear forbids reads
// - block 1 bit 30 guards pages 127-120
// - block 1 other bits guard page groups
// - fetch takes two cycles wide, one narrow
// - status done, fail, busy, irq; read clears all but busy
// - mode bit 3 gates erase/write, bit 4 irq
// - immediate protection now, deferred after reset
`timescale 1ns/100ps
module flash_command_protect_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter bit                 is_block1          = 1'b0,
  parameter logic [TIMER_W-1:0] erase_write_cycles = ERASE_WRITE_CYCLES,
  parameter logic [TIMER_W-1:0] mass_erase_cycles  = MASS_ERASE_CYCLES,
  parameter logic [15:0]        signature_cycles   = SIGNATURE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output array_req_t       arr_req,
  input  wire logic [15:0] arr_rdata,
  input  wire logic [31:0] nv_prot,
  input  wire logic        nv_prot_valid,
  input  wire logic        fetch_req,
  input  wire logic        fetch_wide,
  input  wire logic [15:0] fetch_addr,
  output logic [31:0]      fetch_data,
  output logic             fetch_valid,
  output logic             flash_irq
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WAIT, ST_ERASE_PRE, ST_SIGN, ST_FETCH_HI, ST_FETCH_END
  } state_t;

  function automatic logic [23:0] sign_step(input logic [23:0] acc, input logic [15:0] word);
    sign_step = {acc[22:0], 1'b0} ^ {8'h00, word} ^ (acc[23] ? SIGN_POLY : 24'h000000);
  endfunction : sign_step

  state_t        state;
  state_t        next_state;
  logic [7:0]    mode;
  logic [3:0]    command;
  logic          cmd_pending;
  logic [15:0]   data;
  logic [15:0]   address;
  logic [23:0]   signature;
  logic [31:0]   deferred;
  logic [31:0]   immediate;
  logic [31:0]   deferred_live;
  logic          sealed;
  logic          boot_load;
  logic          done_flag;
  logic          fail_flag;
  logic [15:0]   sign_count;
  logic [3:0]    active_cmd;

  // apb decode
  wire logic acc_first   = psel && penable && !pready;
  wire logic acc_done    = psel && penable && pready;
  wire logic hit_status  = paddr == OFF_STATUS;
  wire logic hit_mode    = paddr == OFF_MODE;
  wire logic hit_command = paddr == OFF_COMMAND;
  wire logic hit_data    = paddr == OFF_DATA;
  wire logic hit_address = paddr == OFF_ADDRESS;
  wire logic hit_sign    = paddr == OFF_SIGNATURE;
  wire logic hit_defer   = paddr == OFF_DEFERRED;
  wire logic hit_immed   = paddr == OFF_IMMEDIATE;
  wire logic mapped      = hit_status || hit_mode || hit_command || hit_data || hit_address
                           || hit_sign || hit_defer || hit_immed;
  wire logic wr_done     = acc_done && pwrite;
  wire logic status_rd   = acc_done && !pwrite && hit_status;
  wire logic busy        = state != ST_IDLE;

  wire logic [31:0] status_word = {28'h0000000, flash_irq, busy, fail_flag, done_flag};
  wire logic [31:0] read_mux =
    hit_status  ? status_word :
    hit_mode    ? {24'h000000, mode} :
    hit_command ? {28'h0000000, command} :
    hit_data    ? {16'h0000, data} :
    hit_address ? {16'h0000, address} :
    hit_sign    ? {8'h00, signature} :
    hit_defer   ? deferred :
    hit_immed   ? immediate : 32'h00000000;

  // only bits that the completed read actually returned are cleared
  wire logic clr_done = status_rd && prdata[STA_DONE];
  wire logic clr_fail = status_rd && prdata[STA_FAIL];
  wire logic clr_irq  = status_rd && prdata[STA_IRQ];

  // a command write is refused while one is already queued or running
  wire logic cmd_write = wr_done && hit_command && !busy && !cmd_pending;

  // protection in force
  wire logic [31:0] prot_eff = immediate & deferred_live;
  logic guard_read_ok;
  logic guard_write_ok;

  page_guard u_guard (
    .prot_word (prot_eff),
    .addr      (address),
    .is_block1 (is_block1),
    .read_ok   (guard_read_ok),
    .write_ok  (guard_write_ok)
  );

  wire logic write_ok   = guard_write_ok && mode[MOD_ERASE_EN];
  wire logic mass_ok    = mode[MOD_ERASE_EN] && data == MASS_KEY_DATA
                          && address == MASS_KEY_ADDR;
  wire logic protect_ok = mode[MOD_ERASE_EN] && (!sealed || data == PROTECT_KEY);

  // timer
  logic               timer_start;
  logic [TIMER_W-1:0] timer_load;
  logic               timer_expired;

  op_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (timer_start),
    .load    (timer_load),
    .expired (timer_expired)
  );

  // sequencer
  array_req_t  next_req;
  logic        take_cmd;
  logic        finish;
  logic        finish_fail;
  logic        capture_data;
  logic        sign_clear;
  logic        sign_accum;
  logic        fetch_lo;
  logic        fetch_hi;

  wire logic sign_reading = sign_count < SIGN_WORDS;
  wire logic sign_last    = sign_count == signature_cycles - 16'd1;
  wire logic fetch_take   = fetch_req && !fetch_valid && !cmd_pending;

  always_comb begin
    next_state   = state;
    next_req     = '{op: ARR_NONE, addr: address, wdata: {16'h0000, data}};
    take_cmd     = 1'b0;
    finish       = 1'b0;
    finish_fail  = 1'b0;
    capture_data = 1'b0;
    sign_clear   = 1'b0;
    sign_accum   = 1'b0;
    fetch_lo     = 1'b0;
    fetch_hi     = 1'b0;
    timer_start  = 1'b0;
    timer_load   = WRITE_CYCLES;
    unique case (state)
      ST_IDLE: begin
        if (cmd_pending) begin
          take_cmd = 1'b1;
          unique case (command)
            CMD_READ, CMD_VERIFY: begin
              if (guard_read_ok) begin
                next_req.op = ARR_READ;
                next_state  = ST_READ;
              end else begin
                finish      = 1'b1;
                finish_fail = 1'b1;
              end
            end
            CMD_WRITE: begin
              if (write_ok) begin
                next_req.op = ARR_WRITE;
                timer_start = 1'b1;
                next_state  = ST_WAIT;
              end else begin
                finish      = 1'b1;
                finish_fail = 1'b1;
              end
            end
            CMD_ERASE_WR, CMD_ERASE_PAGE: begin
              if (write_ok) begin
                next_req.op = ARR_ERASE_PAGE;
                timer_start = 1'b1;
                timer_load  = erase_write_cycles - WRITE_CYCLES;
                next_state  = (command == CMD_ERASE_WR) ? ST_ERASE_PRE : ST_WAIT;
              end else begin
                finish      = 1'b1;
                finish_fail = 1'b1;
              end
            end
            CMD_MASS_ERASE: begin
              if (mass_ok) begin
                next_req.op = ARR_ERASE_USER;
                timer_start = 1'b1;
                timer_load  = mass_erase_cycles;
                next_state  = ST_WAIT;
              end else begin
                finish      = 1'b1;
                finish_fail = 1'b1;
              end
            end
            CMD_SIGNATURE: begin
              if (prot_eff[PROT_READ]) begin
                sign_clear = 1'b1;
                next_state = ST_SIGN;
              end else begin
                finish      = 1'b1;
                finish_fail = 1'b1;
              end
            end
            CMD_PROTECT: begin
              if (protect_ok) begin
                next_req.op    = ARR_STORE_PROT;
                next_req.wdata = deferred;
                timer_start    = 1'b1;
                next_state     = ST_WAIT;
              end else begin
                finish      = 1'b1;
                finish_fail = 1'b1;
              end
            end
            CMD_PING: begin
              finish = 1'b1;
            end
            default: begin
              finish = 1'b0;
            end
          endcase
        end else if (fetch_take) begin
          next_req.op   = ARR_READ;
          next_req.addr = fetch_addr;
          next_state    = fetch_wide ? ST_FETCH_HI : ST_FETCH_END;
        end
      end
      ST_READ: begin
        finish       = 1'b1;
        capture_data = active_cmd == CMD_READ;
        finish_fail  = (active_cmd == CMD_VERIFY) && (arr_rdata != data);
        next_state   = ST_IDLE;
      end
      ST_ERASE_PRE: begin
        if (timer_expired) begin
          next_req.op = ARR_WRITE;
          timer_start = 1'b1;
          next_state  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timer_expired) begin
          finish     = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_SIGN: begin
        if (sign_reading) begin
          next_req.op   = ARR_READ;
          next_req.addr = {sign_count[14:0], 1'b0};
        end
        // read data trails the request by one cycle
        sign_accum = (sign_count != 16'd0) && (sign_count <= SIGN_WORDS);
        if (sign_last) begin
          finish     = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_FETCH_HI: begin
        next_req.op   = ARR_READ;
        next_req.addr = 16'(fetch_addr + 16'd2);
        fetch_lo      = 1'b1;
        next_state    = ST_FETCH_END;
      end
      ST_FETCH_END: begin
        fetch_hi   = fetch_wide;
        fetch_lo   = !fetch_wide;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire logic irq_event = finish && mode[MOD_IRQ_EN];

  // apb response, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= acc_first;
      pslverr <= acc_first && !mapped;
      if (acc_first) begin
        prdata <= read_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode      <= MODE_RESET;
      address   <= ADDRESS_RESET;
      deferred  <= DEFERRED_RESET;
      immediate <= IMMEDIATE_RESET;
    end else if (clk_en && wr_done) begin
      if (hit_mode) begin
        mode <= pwdata[7:0];
      end
      if (hit_address) begin
        address <= pwdata[15:0];
      end
      if (hit_defer) begin
        deferred <= pwdata;
      end
      if (hit_immed) begin
        immediate <= pwdata;
      end
    end
  end

  // data register: a read result wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= DATA_RESET;
    end else if (clk_en) begin
      if (capture_data) begin
        data <= arr_rdata;
      end else if (wr_done && hit_data) begin
        data <= pwdata[15:0];
      end
    end
  end

  // command register and queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command     <= CMD_NULL;
      cmd_pending <= 1'b0;
      active_cmd  <= CMD_NULL;
    end else if (clk_en) begin
      if (cmd_write) begin
        command     <= pwdata[3:0];
        cmd_pending <= 1'b1;
      end else if (take_cmd) begin
        cmd_pending <= 1'b0;
        active_cmd  <= command;
        if (command <= CMD_MASS_ERASE) begin
          command <= CMD_EXECUTED;
        end
      end
    end
  end

  // status flags; a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      flash_irq <= 1'b0;
    end else if (clk_en) begin
      done_flag <= finish || (done_flag && !clr_done);
      fail_flag <= (finish && finish_fail) || (fail_flag && !clr_fail);
      flash_irq <= irq_event || (flash_irq && !clr_irq);
    end
  end

  // sequencer state and array request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      arr_req <= '{op: ARR_NONE, addr: 16'h0000, wdata: 32'h00000000};
    end else if (clk_en) begin
      state   <= next_state;
      arr_req <= next_req;
    end
  end

  // signature engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signature  <= SIGNATURE_RESET;
      sign_count <= 16'h0000;
    end else if (clk_en) begin
      if (sign_clear) begin
        signature  <= SIGNATURE_RESET;
        sign_count <= 16'h0000;
      end else if (state == ST_SIGN) begin
        sign_count <= sign_count + 16'd1;
        if (sign_accum) begin
          signature <= sign_step(signature, arr_rdata);
        end
      end
    end
  end

  // deferred protection: loaded once after reset, sealed by the protect command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_load     <= 1'b1;
      sealed        <= 1'b0;
      deferred_live <= PROT_OPEN;
    end else if (clk_en) begin
      if (boot_load) begin
        boot_load     <= 1'b0;
        sealed        <= nv_prot_valid;
        deferred_live <= nv_prot_valid ? nv_prot : PROT_OPEN;
      end else if (finish && active_cmd == CMD_PROTECT && state == ST_WAIT) begin
        sealed <= 1'b1;
      end else if (finish && active_cmd == CMD_MASS_ERASE && state == ST_WAIT) begin
        sealed        <= 1'b0;
        deferred_live <= PROT_OPEN;
      end
    end
  end

  // instruction fetch, 16-bit array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_data  <= 32'h00000000;
      fetch_valid <= 1'b0;
    end else if (clk_en) begin
      fetch_valid <= state == ST_FETCH_END;
      if (fetch_lo) begin
        fetch_data <= {16'h0000, arr_rdata};
      end else if (fetch_hi) begin
        fetch_data[31:16] <= arr_rdata;
      end
    end
  end

endmodule : flash_command_protect_ctrl

// *** bench/flash_ctrl_sva.sv ***
// port assertions of the flash command controller
`timescale 1ns/100ps
module flash_ctrl_sva
  import flash_ctrl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire array_req_t  arr_req,
  input wire logic        fetch_wide,
  input wire logic [31:0] fetch_data,
  input wire logic        fetch_valid,
  input wire logic        flash_irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire stat_rd = psel && penable && pready && !pwrite && paddr == OFF_STATUS;
  a_setup_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("no single wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (psel && penable && pready && paddr == 8'h14 |-> pslverr)
    else $error("hole not refused");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error reply");
  a_irq_clear: assert property ($fell(flash_irq) |-> $past(stat_rd))
    else $error("irq fell without status read");
  a_fetch_narrow: assert property (fetch_valid && !fetch_wide |-> fetch_data[31:16] == 16'h0)
    else $error("narrow fetch upper half");
  a_fetch_pulse: assert property (fetch_valid |=> !fetch_valid)
    else $error("fetch valid too long");
  a_write_gap: assert property (arr_req.op == ARR_WRITE |=> arr_req.op != ARR_WRITE [*8])
    else $error("writes too close");
endmodule : flash_ctrl_sva
bind flash_command_protect_ctrl flash_ctrl_sva i_flash_ctrl_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .arr_req, .fetch_wide, .fetch_data, .fetch_valid, .flash_irq);

// *** bench/flash_array_model.sv ***
// behavioural flash array behind the controller
`timescale 1ns/100ps
module flash_array_model
  import flash_ctrl_pkg::*;
(
  input  wire logic       pclk,
  input  wire array_req_t req,
  output logic [15:0]     rdata
);
  logic [15:0] mem [256];
  logic [15:0] noise = 16'h0000;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h1000 + 16'(i);
    end
  end
  // word valid only while the read request stands, noise otherwise
  assign rdata = (req.op == ARR_READ) ? mem[req.addr[8:1]] : noise;
  always @(posedge pclk) begin
    noise <= ~noise;
    case (req.op)
      ARR_WRITE: mem[req.addr[8:1]] <= req.wdata[15:0];
      ARR_ERASE_PAGE, ARR_ERASE_USER: foreach (mem[i]) mem[i] <= 16'hffff;
      default: ;
    endcase
  end
endmodule : flash_array_model

// *** bench/tb_top.sv ***
// self-checking bench of the flash command controller
`timescale 1ns/100ps
module tb_top
  import flash_ctrl_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        clk_en = 1'b1;
  logic        fetch_req = 1'b0;
  logic        fetch_wide = 1'b0;
  logic        pready, pslverr, err, fetch_valid, flash_irq;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] fetch_addr = 16'h0;
  logic [15:0] arr_rdata;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, fetch_data, r;
  array_req_t  arr_req;
  int          num_errors = 0;
  int          samples_checked = 0;

  // short counts keep erase runs brief
  flash_command_protect_ctrl #(.erase_write_cycles(1300), .mass_erase_cycles(2000), .signature_cycles(40))
    i_flash_command_protect_ctrl (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .arr_req, .arr_rdata, .nv_prot(32'h0), .nv_prot_valid(1'b0), .fetch_req,
    .fetch_wide, .fetch_addr, .fetch_data, .fetch_valid, .flash_irq);
  flash_array_model i_flash_array_model (.pclk, .req(arr_req), .rdata(arr_rdata));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // polling reads also clear the sticky flags
  task automatic run(input logic [3:0] c, input logic [3:0] e);
    apb(1'b1, OFF_COMMAND, {28'h0, c});
    do apb(1'b0, OFF_STATUS, 32'h0); while (r[0] !== 1'b1);
    chk({28'h0, r[3:0]}, {28'h0, e});
  endtask : run

  task automatic fetch(input logic w, input logic [31:0] e);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fetch_wide <= w;
    fetch_addr <= 16'h8;
    do @(posedge pclk); while (fetch_valid !== 1'b1);
    chk(fetch_data, e);
    fetch_req <= 1'b0;
  endtask : fetch

  task automatic t_reset();
    apb(1'b0, OFF_MODE, 32'h0);
    chk(r, 32'h80);
    apb(1'b0, OFF_SIGNATURE, 32'h0);
    chk(r, 32'hffffff);
    apb(1'b0, OFF_IMMEDIATE, 32'h0);
    chk(r, 32'hffffffff);
    apb(1'b0, OFF_DEFERRED, 32'h0);
    chk(r, 32'h0);
  endtask : t_reset

  task automatic t_read_write();
    apb(1'b1, OFF_ADDRESS, 32'h4);
    run(CMD_READ, 4'h1);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(r, 32'h1002);
    apb(1'b0, OFF_COMMAND, 32'h0);
    chk(r, 32'h7);
    apb(1'b1, OFF_DATA, 32'h1234);
    run(CMD_WRITE, 4'h3);
    apb(1'b1, OFF_MODE, 32'h98);
    run(CMD_WRITE, 4'h9);
    run(CMD_READ, 4'h9);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(r, 32'h1234);
  endtask : t_read_write

  task automatic t_guard();
    apb(1'b1, OFF_DATA, 32'h5555);
    run(CMD_VERIFY, 4'hb);
    apb(1'b1, OFF_IMMEDIATE, 32'h7fffffff);
    run(CMD_READ, 4'hb);
    apb(1'b1, OFF_IMMEDIATE, 32'hfffffffe);
    run(CMD_WRITE, 4'hb);
    apb(1'b1, OFF_IMMEDIATE, 32'hffffffff);
    run(CMD_PING, 4'h9);
    fetch(1'b0, 32'h00001004);
    fetch(1'b1, 32'h10051004);
  endtask : t_guard

  task automatic t_mass();
    run(CMD_MASS_ERASE, 4'hb);
    apb(1'b1, OFF_DATA, {16'h0, MASS_KEY_DATA});
    apb(1'b1, OFF_ADDRESS, {16'h0, MASS_KEY_ADDR});
    run(CMD_MASS_ERASE, 4'h9);
    apb(1'b1, OFF_ADDRESS, 32'h4);
    run(CMD_READ, 4'h9);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(r, 32'hffff);
  endtask : t_mass

  // a queued ping must wait while the enable is low
  task automatic t_freeze();
    apb(1'b1, OFF_COMMAND, {28'h0, CMD_PING});
    clk_en <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, flash_irq}, 32'h0);
    clk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, flash_irq}, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h9);
  endtask : t_freeze

  task automatic t_erase();
    apb(1'b1, OFF_DATA, 32'habcd);
    run(CMD_ERASE_WR, 4'h9);
    run(CMD_READ, 4'h9);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(r, 32'habcd);
    run(CMD_ERASE_PAGE, 4'h9);
    run(CMD_READ, 4'h9);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(r, 32'hffff);
    run(CMD_PROTECT, 4'h9);
    run(CMD_PROTECT, 4'hb);
    apb(1'b1, OFF_DATA, {16'h0, PROTECT_KEY});
    run(CMD_PROTECT, 4'h9);
  endtask : t_erase

  // shortened run sums words 0 to 38, all erased
  task automatic t_sign();
    logic [23:0] s;
    s = SIGNATURE_RESET;
    for (int i = 0; i < 39; i++) begin
      s = {s[22:0], 1'b0} ^ 24'h00ffff ^ (s[23] ? SIGN_POLY : 24'h000000);
    end
    run(CMD_SIGNATURE, 4'h9);
    apb(1'b0, OFF_SIGNATURE, 32'h0);
    chk(r, {8'h00, s});
  endtask : t_sign

  task automatic t_reserved();
    for (int c = 7; c < 15; c++) begin
      if (c != 11 && c != 12) begin
        apb(1'b1, OFF_COMMAND, 32'(c));
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(r, 32'h0);
      end
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_reserved

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    forever #20 pclk = ~pclk;
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_read_write();
    t_guard();
    t_mass();
    t_freeze();
    t_erase();
    t_sign();
    t_reserved();
    finish_test();
  end

  initial begin
    #(40 * 60000);
    num_errors++;
    finish_test();
  end
endmodule : tb_top
